// file: core/fcf_pkg.sv
/*
 * Shared constants for the flash configuration and flag status bank:
 * command codes, register bit positions, reset values, link widths.
 * Assumes a serial host that frames every command with chip select.
 */
package fcf_pkg;

	// Command codes handled by this bank
	localparam logic [7:0] CMD_WREN     = 8'h06;
	localparam logic [7:0] CMD_WRDI     = 8'h04;
	localparam logic [7:0] CMD_RD_EVCFG = 8'h65;
	localparam logic [7:0] CMD_WR_EVCFG = 8'h61;
	localparam logic [7:0] CMD_RD_FLAG  = 8'h70;
	localparam logic [7:0] CMD_CLR_FLAG = 8'h50;

	// Enhanced configuration fields
	localparam int         EV_QUAD_BIT  = 7;
	localparam int         EV_DUAL_BIT  = 6;
	localparam int         EV_HOLD_BIT  = 4;
	localparam int         EV_ACCEL_BIT = 3;
	localparam logic [7:0] EV_RSVD_MASK = 8'h20;
	localparam logic [7:0] EV_RESET     = 8'hDF;
	localparam int         EV_DRV_MSB   = 2;
	// Flag status after reset: controller ready, nothing recorded
	localparam logic [7:0] FSR_RESET    = 8'h80;
	localparam logic [2:0] DRV_RSVD_A   = 3'h0;
	localparam logic [2:0] DRV_RSVD_B   = 3'h4;

	// Link widths and byte counting
	localparam logic [2:0] W_EXT        = 3'h1;
	localparam logic [2:0] W_DUAL       = 3'h2;
	localparam logic [2:0] W_QUAD       = 3'h4;
	localparam logic [3:0] BITS_BYTE    = 4'h8;
	localparam logic [1:0] NB_CMD       = 2'h1;
	localparam logic [1:0] NB_DATA      = 2'h2;
	localparam logic [1:0] NB_MAX       = 2'h3;

	// Output enable masks per protocol
	localparam logic [3:0] OE_EXT       = 4'h2;
	localparam logic [3:0] OE_DUAL      = 4'h3;
	localparam logic [3:0] OE_QUAD      = 4'hF;

	// Bits moved per serial clock; quad wins over dual
	function automatic logic [2:0] bits_per_clk(input logic quad, input logic dual);
		bits_per_clk = quad ? W_QUAD : (dual ? W_DUAL : W_EXT);
	endfunction : bits_per_clk

endpackage : fcf_pkg

// file: core/fcf_link.sv
/*
 * Serial-clock side of the register bank: shifts in command and data
 * bytes and drives register read data on the data pins.
 * Assumes protocol inputs are stable while chip select is low and that
 * the system side reads cmd/data/count only after the frame has ended.
 */
module fcf_link (
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic [3:0] dq_in,
	output logic      [3:0] dq_out,
	output logic      [3:0] dq_oe,
	input  wire logic       quad_in,
	input  wire logic       dual_in,
	input  wire logic [7:0] enhanced_volatile_config_in,
	input  wire logic [7:0] fsr_in,
	output logic      [7:0] cmd_q,
	output logic      [7:0] data_q,
	output logic      [1:0] nbytes_q
);

	logic       started_r;
	logic       quad_r;
	logic       dual_r;
	logic [3:0] bi_r;
	logic [7:0] sh_r;
	logic [7:0] enhanced_volatile_config_s1_r;
	logic [7:0] enhanced_volatile_config_s2_r;
	logic [7:0] fsr_s1_r;
	logic [7:0] fsr_s2_r;

	// Frame bookkeeping restarts on the first edge after select
	wire       first    = ~started_r;
	wire       q_cur    = first ? quad_in : quad_r;
	wire       d_cur    = first ? dual_in : dual_r;
	wire [2:0] w        = fcf_pkg::bits_per_clk(q_cur, d_cur);
	wire [2:0] w_r      = fcf_pkg::bits_per_clk(quad_r, dual_r);
	wire [3:0] bi_base  = first ? 4'h0 : bi_r;
	wire [1:0] nb_base  = first ? 2'h0 : nbytes_q;
	wire [7:0] sh_base  = first ? 8'h00 : sh_r;
	wire [3:0] bi_sum   = bi_base + {1'b0, w};
	wire       done     = bi_sum == fcf_pkg::BITS_BYTE;
	wire [7:0] sh_nxt   = (w == fcf_pkg::W_QUAD) ? {sh_base[3:0], dq_in} :
	                      (w == fcf_pkg::W_DUAL) ? {sh_base[5:0], dq_in[1:0]} :
	                      {sh_base[6:0], dq_in[0]};
	wire [1:0] nb_nxt   = (done && nb_base != fcf_pkg::NB_MAX) ? nb_base + 2'h1 : nb_base;

	// Read data: no address or dummy cycles after the command byte
	wire       rd_cmd   = cmd_q == fcf_pkg::CMD_RD_EVCFG || cmd_q == fcf_pkg::CMD_RD_FLAG;
	wire       rd_act   = nbytes_q != 2'h0 && rd_cmd;
	wire [7:0] rd_val   = (cmd_q == fcf_pkg::CMD_RD_FLAG) ? fsr_s2_r : enhanced_volatile_config_s2_r;
	wire [7:0] rd_sh    = rd_val << bi_r;
	wire [3:0] out_bits = (w_r == fcf_pkg::W_QUAD) ? rd_sh[7:4] :
	                      (w_r == fcf_pkg::W_DUAL) ? {2'h0, rd_sh[7:6]} :
	                      {2'h0, rd_sh[7], 1'b0};
	wire [3:0] oe_mask  = (w_r == fcf_pkg::W_QUAD) ? fcf_pkg::OE_QUAD :
	                      (w_r == fcf_pkg::W_DUAL) ? fcf_pkg::OE_DUAL : fcf_pkg::OE_EXT;

	// Select high ends the frame
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			started_r <= 1'b0;
		end else begin
			started_r <= 1'b1;
		end
	end

	// Shift register, byte counter and protocol latched for the frame
	always_ff @(posedge sck) begin
		quad_r   <= q_cur;
		dual_r   <= d_cur;
		sh_r     <= sh_nxt;
		bi_r     <= done ? 4'h0 : bi_sum;
		nbytes_q <= nb_nxt;
	end

	// First and second byte of the frame
	always_ff @(posedge sck) begin
		if (done && nb_base == 2'h0) begin
			cmd_q <= sh_nxt;
		end
		if (done && nb_base == fcf_pkg::NB_CMD) begin
			data_q <= sh_nxt;
		end
	end

	// Two-stage synchronisers for register contents
	always_ff @(posedge sck) begin
		enhanced_volatile_config_s1_r <= enhanced_volatile_config_in;
		enhanced_volatile_config_s2_r <= enhanced_volatile_config_s1_r;
		fsr_s1_r  <= fsr_in;
		fsr_s2_r  <= fsr_s1_r;
	end

	// Output on falling edge, repeating the register until deselect
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			dq_out <= 4'h0;
			dq_oe  <= 4'h0;
		end else begin
			dq_out <= out_bits;
			dq_oe  <= rd_act ? oe_mask : 4'h0;
		end
	end

endmodule : fcf_link

// file: core/fcf_regs.sv
/*
 * Enhanced configuration and flag status registers of a serial flash.
 * Holds both registers on clk, runs the serial link on sck through
 * fcf_link, and exports configuration to the array logic.
 * Assumes the array controller drives status levels and one-cycle
 * event pulses on clk, and that chip select stays high for at least
 * four clk periods between frames.
 */

module fcf_regs (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic [3:0] dq_in,
	output logic      [3:0] dq_out,
	output logic      [3:0] dq_oe,
	input  wire logic       pe_busy,
	input  wire logic       erase_susp,
	input  wire logic       prog_susp,
	input  wire logic       erase_fail,
	input  wire logic       prog_fail,
	input  wire logic       prot_hit_erase,
	input  wire logic       prot_hit_prog,
	input  wire logic       otp_locked_hit,
	input  wire logic       zero_to_one_try,
	input  wire logic       pattern_mult64,
	input  wire logic       program_supply_high_level,
	input  wire logic       supply_invalid,
	input  wire logic       erase_start,
	input  wire logic       prog_start,
	output logic            quad_en,
	output logic            dual_en,
	output logic            hold_reset_en,
	output logic            accel_en,
	output logic      [2:0] drive_code,
	output logic            drive_code_ok,
	output logic            write_en_latch,
	output logic            pe_cmd_err,
	output logic      [7:0] enhanced_volatile_config_q,
	output logic      [7:0] fsr_q
);

	// Register state on clk
	logic [7:0] enhanced_volatile_config_r;
	logic [7:0] enhanced_volatile_config_nxt;
	logic       wel_r;
	logic       wel_nxt;
	logic       err_erase_r;
	logic       err_erase_nxt;
	logic       err_prog_r;
	logic       err_prog_nxt;
	logic       err_supply_r;
	logic       err_supply_nxt;
	logic       err_prot_r;
	logic       err_prot_nxt;
	logic       pe_err_r;

	// Chip select synchroniser and frame end detector
	logic       cs_s1_r;
	logic       cs_s2_r;
	logic       cs_s3_r;

	// Values handed over by the serial side
	logic [7:0] lk_cmd;
	logic [7:0] lk_data;
	logic [1:0] lk_nb;

	// Serial side of the bank
	fcf_link u_link (
		.sck      (sck),
		.cs_n     (cs_n),
		.dq_in    (dq_in),
		.dq_out   (dq_out),
		.dq_oe    (dq_oe),
		.quad_in  (quad_en),
		.dual_in  (dual_en),
		.enhanced_volatile_config_in  (enhanced_volatile_config_r),
		.fsr_in   (fsr_q),
		.cmd_q    (lk_cmd),
		.data_q   (lk_data),
		.nbytes_q (lk_nb)
	);

	// Chip select crosses to clk through two flip-flops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_s3_r <= 1'b1;
		end else begin
			cs_s1_r <= cs_n;
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
		end
	end

	// Frame end: the serial clock is idle, link values are stable
	wire frame_end = cs_s2_r & ~cs_s3_r;

	// Command decode, only on whole bytes
	wire cmd_only  = lk_nb == fcf_pkg::NB_CMD;
	wire has_data  = lk_nb >= fcf_pkg::NB_DATA;
	wire is_wren   = frame_end & cmd_only & (lk_cmd == fcf_pkg::CMD_WREN);
	wire is_wrdi   = frame_end & cmd_only & (lk_cmd == fcf_pkg::CMD_WRDI);
	wire is_clr    = frame_end & cmd_only & (lk_cmd == fcf_pkg::CMD_CLR_FLAG);
	wire is_wr_ev  = frame_end & has_data & (lk_cmd == fcf_pkg::CMD_WR_EVCFG);

	// The write is executed only with the write enable latch set
	wire ev_store  = is_wr_ev & wel_r;

	// Stored value keeps the reserved bit at zero
	wire [7:0] ev_wval = lk_data & ~fcf_pkg::EV_RSVD_MASK;

	// Configuration write applies at frame end, never mid-frame
	always_comb begin
		enhanced_volatile_config_nxt = enhanced_volatile_config_r;
		if (ev_store) begin
			enhanced_volatile_config_nxt = ev_wval;
		end
	end

	// Write enable latch: set, cleared, consumed by the config write
	always_comb begin
		wel_nxt = wel_r;
		if (is_wren) begin
			wel_nxt = 1'b1;
		end else if (is_wrdi || ev_store) begin
			wel_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enhanced_volatile_config_r <= fcf_pkg::EV_RESET;
			wel_r  <= 1'b0;
		end else begin
			enhanced_volatile_config_r <= enhanced_volatile_config_nxt;
			wel_r  <= wel_nxt;
		end
	end

	// Protocol decode; quad wins when both bits are low
	assign quad_en = ~enhanced_volatile_config_r[fcf_pkg::EV_QUAD_BIT];
	assign dual_en = enhanced_volatile_config_r[fcf_pkg::EV_QUAD_BIT] & ~enhanced_volatile_config_r[fcf_pkg::EV_DUAL_BIT];

	// Pin function, acceleration and drive strength
	assign hold_reset_en = enhanced_volatile_config_r[fcf_pkg::EV_HOLD_BIT];
	assign accel_en      = ~enhanced_volatile_config_r[fcf_pkg::EV_ACCEL_BIT];
	assign drive_code    = enhanced_volatile_config_r[fcf_pkg::EV_DRV_MSB:0];
	assign drive_code_ok = drive_code != fcf_pkg::DRV_RSVD_A &&
	                       drive_code != fcf_pkg::DRV_RSVD_B;
	assign write_en_latch = wel_r;
	assign enhanced_volatile_config_q         = enhanced_volatile_config_r;

	// Any recorded error blocks new program or erase commands
	wire any_err = err_erase_r | err_prog_r | err_supply_r | err_prot_r;

	// Starting an operation while an error stands is an error itself
	wire erase_blocked = erase_start & any_err;
	wire prog_blocked  = prog_start & any_err;

	// Zero-to-one attempt with the high supply on a 64-bit pattern
	wire z2o_err = zero_to_one_try & pattern_mult64 & program_supply_high_level;

	// Error set terms
	wire set_erase  = erase_fail | prot_hit_erase | erase_blocked;
	wire set_prog   = prog_fail | prot_hit_prog | otp_locked_hit |
	                  z2o_err | prog_blocked;
	wire set_supply = supply_invalid & pe_busy;
	wire set_prot   = prot_hit_erase | prot_hit_prog | otp_locked_hit;

	// Sticky errors; a new event wins over a clear in the same cycle
	always_comb begin
		err_erase_nxt  = err_erase_r;
		err_prog_nxt   = err_prog_r;
		err_supply_nxt = err_supply_r;
		err_prot_nxt   = err_prot_r;
		if (is_clr) begin
			err_erase_nxt  = 1'b0;
			err_prog_nxt   = 1'b0;
			err_supply_nxt = 1'b0;
			err_prot_nxt   = 1'b0;
		end
		if (set_erase) begin
			err_erase_nxt = 1'b1;
		end
		if (set_prog) begin
			err_prog_nxt = 1'b1;
		end
		if (set_supply) begin
			err_supply_nxt = 1'b1;
		end
		if (set_prot) begin
			err_prot_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			err_erase_r  <= 1'b0;
			err_prog_r   <= 1'b0;
			err_supply_r <= 1'b0;
			err_prot_r   <= 1'b0;
			pe_err_r     <= 1'b0;
		end else begin
			err_erase_r  <= err_erase_nxt;
			err_prog_r   <= err_prog_nxt;
			err_supply_r <= err_supply_nxt;
			err_prot_r   <= err_prot_nxt;
			pe_err_r     <= erase_blocked | prog_blocked;
		end
	end

	assign pe_cmd_err = pe_err_r;

	// Flag status: status bits track the controller directly
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fsr_q <= fcf_pkg::FSR_RESET;
		end else begin
			fsr_q <= {~pe_busy,
			          erase_susp,
			          err_erase_r,
			          err_prog_r,
			          err_supply_r,
			          prog_susp,
			          err_prot_r,
			          1'b0};
		end
	end

endmodule : fcf_regs

// file: sim/fcf_host.sv
/* Serial host model for the register bank: frames commands on sck, cs_n, dq_in.
   Assumes the caller passes the bus width now in force; sck runs only in frames. */
module fcf_host (
	output logic            sck,
	output logic            cs_n,
	output logic      [3:0] dq_in,
	input  wire logic [3:0] dq_out,
	input  wire logic [3:0] dq_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus, link clock parked low; a rising select clears the frame state
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		dq_in = 4'hA;
		#1 cs_n = 1'b1;
	end

	// One frame of nb bytes, w bits per edge, MSB first; rd keeps the last byte seen
	task automatic frame(input logic [7:0] c, input logic [7:0] d, input int nb,
		input int w, output logic [7:0] rd, output logic [3:0] oe);
		logic [15:0] sh;
		int          i;
		sh = {c, d};
		rd = 8'h00;
		oe = 4'h0;
		cs_n = 1'b0;
		for (i = 0; i < nb * 8 / w; i++) begin
			dq_in = (w == 4) ? sh[15:12] : (w == 2) ? {sh[13:12], sh[15:14]} : {sh[14:12], sh[15]};
			sh = sh << w;
			#3 sck = 1'b1;
			rd = (w == 4) ? {rd[3:0], dq_out} : (w == 2) ? {rd[5:0], dq_out[1:0]} : {rd[6:0], dq_out[1]};
			oe = dq_oe; // Enables seen at the last edge of the frame
			#3 sck = 1'b0;
		end
		#3 cs_n = 1'b1;
		dq_in = ~dq_in; // Released lines do not keep their last value
		#60;
	endtask : frame
endmodule : fcf_host

// file: sim/fcf_regs_checker.sv
/* Port assertions for the flash configuration and flag status bank.
   Bound into every fcf_regs instance; only the clk domain is watched. */
module fcf_regs_checker (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       cs_n,
	input wire logic       pe_busy,
	input wire logic       erase_susp,
	input wire logic       prog_susp,
	input wire logic       erase_fail,
	input wire logic       prot_hit_erase,
	input wire logic       prot_hit_prog,
	input wire logic       otp_locked_hit,
	input wire logic       supply_invalid,
	input wire logic       erase_start,
	input wire logic       prog_start,
	input wire logic       quad_en,
	input wire logic       dual_en,
	input wire logic       hold_reset_en,
	input wire logic       accel_en,
	input wire logic [2:0] drive_code,
	input wire logic       drive_code_ok,
	input wire logic       pe_cmd_err,
	input wire logic [7:0] enhanced_volatile_config_q,
	input wire logic [7:0] fsr_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Configuration outputs follow the stored register
	AST_QUAD: assert property (quad_en == !enhanced_volatile_config_q[7])
		else $error("Quad select does not follow config");
	AST_DUAL: assert property (dual_en == (enhanced_volatile_config_q[7] && !enhanced_volatile_config_q[6]))
		else $error("Dual select wrong or beats quad");
	AST_PINS: assert property (hold_reset_en == enhanced_volatile_config_q[4] &&
		accel_en == !enhanced_volatile_config_q[3])
		else $error("Hold or acceleration enable wrong");
	AST_DRIVE: assert property (drive_code == enhanced_volatile_config_q[2:0] &&
		drive_code_ok == (enhanced_volatile_config_q[1:0] != 2'h0))
		else $error("Drive code or validity wrong");
	AST_CFG_LATE: assert property (!$stable(enhanced_volatile_config_q) |-> $past(cs_n) && $past(cs_n, 2))
		else $error("Config changed inside a frame");
	AST_RSVD: assert property (!enhanced_volatile_config_q[5] && !fsr_q[0])
		else $error("Reserved bit not zero");

	// Status bits track the controller one cycle later
	AST_BUSY: assert property (fsr_q[7] == !$past(pe_busy))
		else $error("Ready bit wrong");
	AST_SUSP: assert property (fsr_q[6] == $past(erase_susp) &&
		fsr_q[2] == $past(prog_susp))
		else $error("Suspend bit wrong");

	// Error bits show two cycles after their event: sticky flop, then status flop
	AST_ERASE_ERR: assert property (erase_fail || prot_hit_erase |-> ##2 fsr_q[5])
		else $error("Erase error not recorded");
	AST_PROT_ERR: assert property (prot_hit_erase || prot_hit_prog || otp_locked_hit
		|-> ##2 fsr_q[1])
		else $error("Protection error not recorded");
	AST_SUPPLY_ERR: assert property (supply_invalid && pe_busy |-> ##2 fsr_q[3])
		else $error("Supply error not recorded");
	// Error bits fall only after a frame has ended
	AST_STICKY: assert property (|($past(fsr_q) & ~fsr_q & 8'h3A)
		|-> $past(cs_n) && $past(cs_n, 2))
		else $error("Error bit cleared without a command");
	// Status lags the sticky flops by one cycle, so look at it one cycle after the start
	AST_START_ERR: assert property ((erase_start || prog_start) ##1 |(fsr_q & 8'h3A)
		|-> pe_cmd_err)
		else $error("Start over standing error not flagged");
endmodule : fcf_regs_checker

bind fcf_regs fcf_regs_checker chk (.clk, .sys_rst, .cs_n, .pe_busy, .erase_susp, .prog_susp,
	.erase_fail, .prot_hit_erase, .prot_hit_prog, .otp_locked_hit, .supply_invalid, .erase_start,
	.prog_start, .quad_en, .dual_en, .hold_reset_en, .accel_en, .drive_code, .drive_code_ok,
	.pe_cmd_err, .enhanced_volatile_config_q, .fsr_q);

// file: sim/fcf_regs_bench.sv
/* Self-checking bench for fcf_regs: register commands through fcf_host,
   controller levels and event pulses driven on clk. */
module fcf_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clk, sys_rst, sck, cs_n, seen;
	logic [3:0] dq_in, dq_out, dq_oe, oe;
	logic [4:0] lv; // busy, erase susp, prog susp, 64-bit pattern, supply high
	logic [8:0] ev; // erase/prog fail, prot erase/prog, otp, 0->1, supply, starts
	logic       quad_en, dual_en, hold_reset_en, accel_en, drive_code_ok;
	logic       write_en_latch, pe_cmd_err;
	logic [2:0] drive_code;
	logic [7:0] enhanced_volatile_config_q, fsr_q, rd, cur;
	int         err_count, n_tests, i, w;
	wire  [7:0] outs_now = {quad_en, dual_en, hold_reset_en, accel_en, drive_code, drive_code_ok};
	logic [7:0] wv [4] = '{8'hBC, 8'h21, 8'h7A, 8'hFF};
	logic [7:0] wx [4] = '{8'h9C, 8'h01, 8'h5A, 8'hDF};
	logic [4:0] lt [9] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h03, 5'h01, 5'h10, 5'h1C};
	logic [8:0] et [9] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h020, 9'h040, 9'h000};
	logic [7:0] xt [9] = '{8'hA0, 8'h90, 8'hA2, 8'h92, 8'h82, 8'h90, 8'h80, 8'h08, 8'h44};
	logic [7:0] mt [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hCF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	fcf_host host (.sck, .cs_n, .dq_in, .dq_out, .dq_oe);
	fcf_regs dut (.clk, .sys_rst, .sck, .cs_n, .dq_in, .dq_out, .dq_oe,
		.pe_busy(lv[4]), .erase_susp(lv[3]), .prog_susp(lv[2]), .pattern_mult64(lv[1]),
		.program_supply_high_level(lv[0]), .erase_fail(ev[0]), .prog_fail(ev[1]),
		.prot_hit_erase(ev[2]), .prot_hit_prog(ev[3]), .otp_locked_hit(ev[4]),
		.zero_to_one_try(ev[5]), .supply_invalid(ev[6]), .erase_start(ev[7]),
		.prog_start(ev[8]), .quad_en, .dual_en, .hold_reset_en, .accel_en, .drive_code,
		.drive_code_ok, .write_en_latch, .pe_cmd_err, .enhanced_volatile_config_q, .fsr_q);

	// System clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Masked byte comparison
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		n_tests++;
		if ((got & m) !== (exp & m)) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	// One command frame at the current width
	task automatic cmd(input logic [7:0] c, input logic [7:0] d, input int nb);
		host.frame(c, d, nb, w, rd, oe);
	endtask : cmd

	// Event pulse of one cycle; reports whether a start error was flagged
	task automatic pulse(input logic [8:0] m, output logic s);
		s = 1'b0;
		@(posedge clk) ev <= m;
		@(posedge clk) ev <= 9'h000;
		repeat (3) begin
			#1 s = s | pe_cmd_err;
			@(posedge clk);
		end
		#1;
	endtask : pulse

	// Expected configuration outputs for a register value
	function automatic logic [7:0] outs(input logic [7:0] e);
		outs = {~e[7], e[7] & ~e[6], e[4], ~e[3], e[2:0], e[1:0] != 2'h0};
	endfunction : outs

	// Expected pin enables while read data is driven at a width
	function automatic logic [3:0] oe_exp(input int wd);
		oe_exp = (wd == 4) ? fcf_pkg::OE_QUAD : (wd == 2) ? fcf_pkg::OE_DUAL : fcf_pkg::OE_EXT;
	endfunction : oe_exp

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// Watchdog
	initial begin
		#200000;
		err_count++;
		end_of_test;
	end

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		lv = 5'h00;
		ev = 9'h000;
		w = 1;
		cur = 8'hDF;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk8(enhanced_volatile_config_q, cur, 8'hFF);
		chk8(outs_now, outs(cur), 8'hFF);
		chk8(fsr_q, 8'h80, 8'hFF);
		cmd(fcf_pkg::CMD_WR_EVCFG, 8'h00, 2);
		chk8(enhanced_volatile_config_q, cur, 8'hFF);
		// Config writes and reads across extended, dual, both-low quad and quad
		for (i = 0; i < 4; i++) begin
			cmd(fcf_pkg::CMD_RD_EVCFG, 8'h00, 2);
			chk8(rd, cur, 8'hFF);
			chk8({4'h0, oe}, {4'h0, oe_exp(w)}, 8'hFF);
			cmd(fcf_pkg::CMD_WREN, 8'h00, 1);
			chk8({dq_oe, oe}, 8'h00, 8'hFF);
			chk8({7'h00, write_en_latch}, 8'h01, 8'hFF);
			cmd(fcf_pkg::CMD_WR_EVCFG, wv[i], 2);
			cur = wx[i];
			chk8(enhanced_volatile_config_q, cur, 8'hFF);
			chk8(outs_now, outs(cur), 8'hFF);
			chk8({7'h00, write_en_latch}, 8'h00, 8'hFF);
			w = !cur[7] ? 4 : !cur[6] ? 2 : 1;
			cmd(fcf_pkg::CMD_RD_FLAG, 8'h00, 2);
			chk8(rd, 8'h80, 8'hFF);
		end
		// Each status level and error event, then the clear command
		for (i = 0; i < 9; i++) begin
			@(posedge clk) lv <= lt[i];
			pulse(et[i], seen);
			chk8(fsr_q, xt[i], mt[i]);
			cmd(fcf_pkg::CMD_RD_FLAG, 8'h00, 2);
			chk8(rd, xt[i], mt[i]);
			@(posedge clk) lv <= 5'h00;
			repeat (3) @(posedge clk);
			#1;
			chk8(fsr_q, (xt[i] & 8'h3A) | 8'h80, mt[i]);
			cmd(fcf_pkg::CMD_CLR_FLAG, 8'h00, 1);
			chk8(fsr_q, 8'h80, 8'hFF);
		end
		// Program and erase starts while an error stands, then an erase start after clearing
		pulse(9'h001, seen);
		pulse(9'h100, seen);
		chk8({7'h00, seen}, 8'h01, 8'hFF);
		pulse(9'h080, seen);
		chk8({7'h00, seen}, 8'h01, 8'hFF);
		chk8(fsr_q, 8'h30, 8'h30);
		cmd(fcf_pkg::CMD_CLR_FLAG, 8'h00, 1);
		pulse(9'h080, seen);
		chk8({7'h00, seen}, 8'h00, 8'hFF);
		end_of_test;
	end
endmodule : fcf_regs_bench
